// >>> design/dss_pkg.sv
package dss_pkg;

    // conversion counts; the long ones reappear as top-level parameters
    localparam int CYCLE_COUNTS = 40002;
    localparam int INT_COUNTS   = 10000;
    localparam int RANGE_COUNTS = 20000;
    localparam int IRST_OVR_COUNTS = 6200;
    localparam int IRST_NORM_COUNTS = 150;
    localparam int STROBE_DLY   = 101;

    // least high time of a start pulse, rounded up to whole clocks
    localparam int CLK_PERIOD_NS = 40;
    localparam int START_PULSE_NS = 300;
    localparam int START_CYC    = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_STATUS   = 8'h04;
    localparam logic [7:0] ADR_RESULT   = 8'h08;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

    // field positions
    localparam int CTRL_EN_BIT  = 0;
    localparam int ST_PHASE_LSB = 0;
    localparam int ST_BUSY_BIT  = 2;
    localparam int ST_OVR_BIT   = 3;
    localparam int ST_POL_BIT   = 4;
    localparam int ST_HELD_BIT  = 5;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_OVR_BIT  = 1;
    localparam int IRQ_END_BIT  = 2;
    localparam int IRQ_W        = 3;

    // reset values
    localparam logic            CTRL_EN_RST  = 1'b1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    typedef enum logic [1:0] {PH_NULL, PH_INTEG, PH_DEINT, PH_RESET} dss_phase_t;

    // analogue switch controls
    typedef struct packed {
        logic in_short;      // both inputs shorted to common
        logic ref_charge;    // reference capacitor charging
        logic offset_loop;   // offset storage loop closed
        logic in_to_pins;    // inputs connected to pins
        logic neg_to_common; // negative input tied to common
        logic ref_to_pos;    // reference capacitor onto positive input
        logic ref_pol_pos;   // reference connected in positive sense
        logic reset_loop;    // integrator reset loop closed
    } dss_sw_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } dss_div_t;

endpackage

// >>> design/dss_tick.sv
module dss_tick import dss_pkg::*; #(
    parameter int DIV = 1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // count enable
    output logic      tick
);
    localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

    dss_div_t s_reg;
    dss_div_t s_next;

    always_comb begin
        s_next = s_reg;
        if (s_reg.cnt >= DIV_LAST) begin
            s_next.cnt  = 16'h0000;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt  = s_reg.cnt + 16'h0001;
            s_next.tick = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule

// >>> design/dss_seq.sv
// What this block does
// - every measurement runs offset null, integrate, reference ramp, reset, in order
// - offset null shorts inputs to common, charges reference, closes offset loop
// - integrate opens the loop, connects pins, integrates for a fixed time
// - sign of the integrated signal is caught at the end of integrate
// - ramp ties negative input to common, reference onto positive in the opposing sense
// - reading is the count of ramp clocks until the integrator crosses zero
// - reset ties negative input to common and closes the loop onto positive input
// - reset lasts 150 counts normally, 6200 after an overrange
// - with run/hold high a measurement starts every 40002 counts
// - with run/hold low the cycle in progress finishes and the reading is kept
// - a start pulse over 300ns while held starts a cycle after one null count
// - a start pulse before the full cycle ends is ignored
// - strobe pulses low 101 counts after a full cycle ends
// - busy from integrate start to first clock after crossing; result loaded then
// - overrange set at end of busy past 20000 counts, cleared at next ramp start
// - polarity high for positive input, updated at start of ramp
//
// The Wishbone slave port and the register addresses are this design's own decisions.
module dss_seq import dss_pkg::*; #(
    parameter int CYCLE = CYCLE_COUNTS,
    parameter int INTEG = INT_COUNTS,
    parameter int RANGE = RANGE_COUNTS,
    parameter int IRST_OVR = IRST_OVR_COUNTS,
    parameter int DIV   = 1
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // converter pins
    input  wire logic        run_hold,
    input  wire logic        integ_pos,
    output dss_sw_t          sw,
    output logic             busy,
    output logic             overrange,
    output logic             polarity,
    output logic             strobe_n,
    output logic             irq
);
    localparam logic [15:0] LAST_POS  = 16'(CYCLE - 1);
    localparam logic [15:0] INT_LAST  = 16'(INTEG - 1);
    localparam logic [15:0] RANGE_CNT = 16'(RANGE);
    localparam logic [15:0] IRST_O_LAST = 16'(IRST_OVR - 1);
    localparam logic [15:0] IRST_N_LAST = 16'(IRST_NORM_COUNTS - 1);
    localparam logic [15:0] STB_LAST  = 16'(STROBE_DLY - 1);
    localparam logic [3:0]  START_LIM = 4'(START_CYC);

    typedef struct packed {
        dss_phase_t        phase;
        logic [15:0]       pos;
        logic [15:0]       ph_cnt;
        logic              held;
        logic              kick;
        logic [3:0]        hi_cnt;
        logic              pol_int;
        logic              pol_out;
        logic              busy;
        logic              ovr;
        logic              ovr_irst;
        logic [15:0]       result;
        logic              stb_arm;
        logic [15:0]       stb_cnt;
        logic              strobe_n;
        dss_sw_t           sw;
        logic              ack;
        logic [31:0]       dat;
        logic              en;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic              irq;
    } dss_st_t;

    localparam dss_sw_t SW_NULL = '{in_short: 1'b1, ref_charge: 1'b1, offset_loop: 1'b1,
                                   default: 1'b0};

    dss_st_t s_reg;
    dss_st_t s_next;
    logic    tick;

    dss_tick #(.DIV(DIV)) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    function automatic dss_sw_t sw_of(dss_phase_t ph, logic pol);
        dss_sw_t v;
        v = '0;
        case (ph)
            PH_NULL:  v = SW_NULL;
            PH_INTEG: v.in_to_pins = 1'b1;
            PH_DEINT: begin
                v.neg_to_common = 1'b1;
                v.ref_to_pos    = 1'b1;
                v.ref_pol_pos   = ~pol;
            end
            PH_RESET: begin
                v.neg_to_common = 1'b1;
                v.reset_loop    = 1'b1;
            end
            default:  v = SW_NULL;
        endcase
        return v;
    endfunction

    logic             req;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic             start_now;
    logic             run_ok;

    always_comb begin
        s_next    = s_reg;
        irq_set   = '0;
        irq_clr   = '0;
        start_now = 1'b0;
        run_ok    = run_hold & s_reg.en;
        req       = wb_cyc_i & wb_stb_i & ~s_reg.ack;
        // start pulse width is measured on every clock, not per count
        s_next.hi_cnt = run_ok ? ((s_reg.hi_cnt == START_LIM) ? s_reg.hi_cnt
                                  : s_reg.hi_cnt + 4'h1) : 4'h0;
        if (s_reg.held && run_ok && s_reg.hi_cnt == START_LIM - 4'h1) begin
            s_next.kick = 1'b1;
        end
        if (tick) begin
            s_next.pos    = s_reg.pos + 16'h0001;
            s_next.ph_cnt = s_reg.ph_cnt + 16'h0001;
            s_next.strobe_n = 1'b1;
            if (s_reg.stb_arm) begin
                s_next.stb_cnt = s_reg.stb_cnt + 16'h0001;
                if (s_reg.stb_cnt == STB_LAST) begin
                    s_next.strobe_n = 1'b0;
                    s_next.stb_arm  = 1'b0;
                end
            end
            case (s_reg.phase)
                PH_NULL: begin
                    if (s_reg.held) begin
                        s_next.pos = s_reg.pos;
                        start_now  = s_reg.kick;
                    end else if (s_reg.pos == LAST_POS) begin
                        irq_set[IRQ_END_BIT] = 1'b1;
                        s_next.stb_arm = 1'b1;
                        s_next.stb_cnt = 16'h0000;
                        if (run_ok) begin
                            start_now = 1'b1;
                        end else begin
                            s_next.held = 1'b1;
                            s_next.pos  = s_reg.pos;
                        end
                    end
                end
                PH_INTEG: begin
                    if (s_reg.ph_cnt == INT_LAST) begin
                        s_next.phase   = PH_DEINT;
                        s_next.ph_cnt  = 16'h0000;
                        s_next.pol_int = integ_pos;
                        s_next.pol_out = integ_pos;
                        s_next.ovr     = 1'b0;
                    end
                end
                PH_DEINT: begin
                    // crossing shows as the comparator leaving the caught sign
                    if (integ_pos != s_reg.pol_int || s_reg.ph_cnt == RANGE_CNT) begin
                        s_next.phase  = PH_RESET;
                        s_next.ph_cnt = 16'h0000;
                        s_next.busy   = 1'b0;
                        s_next.result = s_reg.ph_cnt;
                        s_next.ovr_irst = (integ_pos == s_reg.pol_int);
                        s_next.ovr    = (integ_pos == s_reg.pol_int);
                        irq_set[IRQ_DONE_BIT] = 1'b1;
                        irq_set[IRQ_OVR_BIT]  = (integ_pos == s_reg.pol_int);
                    end
                end
                PH_RESET: begin
                    if (s_reg.ph_cnt == (s_reg.ovr_irst ? IRST_O_LAST : IRST_N_LAST)) begin
                        s_next.phase  = PH_NULL;
                        s_next.ph_cnt = 16'h0000;
                    end
                end
                default: s_next.phase = PH_NULL;
            endcase
            if (start_now) begin
                s_next.phase  = PH_INTEG;
                s_next.pos    = 16'h0000;
                s_next.ph_cnt = 16'h0000;
                s_next.held   = 1'b0;
                s_next.kick   = 1'b0;
                s_next.busy   = 1'b1;
            end
        end
        s_next.sw = sw_of(s_next.phase, s_next.pol_int);
        // bus: one wait-free answer a cycle after the request
        s_next.ack = req;
        s_next.dat = 32'h0000_0000;
        if (req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADR_CTRL:     s_next.en = wb_dat_i[CTRL_EN_BIT];
                ADR_IRQ_STAT: irq_clr = wb_dat_i[IRQ_W-1:0];
                ADR_IRQ_MASK: s_next.irq_mask = wb_dat_i[IRQ_W-1:0];
                default:      s_next.en = s_reg.en;
            endcase
        end
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ADR_CTRL:     s_next.dat[CTRL_EN_BIT] = s_reg.en;
                ADR_STATUS: begin
                    s_next.dat[ST_PHASE_LSB +: 2] = s_reg.phase;
                    s_next.dat[ST_BUSY_BIT] = s_reg.busy;
                    s_next.dat[ST_OVR_BIT]  = s_reg.ovr;
                    s_next.dat[ST_POL_BIT]  = s_reg.pol_out;
                    s_next.dat[ST_HELD_BIT] = s_reg.held;
                end
                ADR_RESULT:   s_next.dat[15:0] = s_reg.result;
                ADR_IRQ_STAT: s_next.dat[IRQ_W-1:0] = s_reg.irq_stat;
                ADR_IRQ_MASK: s_next.dat[IRQ_W-1:0] = s_reg.irq_mask;
                default:      s_next.dat = 32'h0000_0000;
            endcase
        end
        // a set in the clearing cycle survives
        s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_set;
        s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg          <= '0;
            s_reg.phase    <= PH_NULL;
            s_reg.sw       <= SW_NULL;
            s_reg.strobe_n <= 1'b1;
            s_reg.en       <= CTRL_EN_RST;
            s_reg.irq_mask <= IRQ_MASK_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o  = s_reg.dat;
    assign wb_ack_o  = s_reg.ack;
    assign sw        = s_reg.sw;
    assign busy      = s_reg.busy;
    assign overrange = s_reg.ovr;
    assign polarity  = s_reg.pol_out;
    assign strobe_n  = s_reg.strobe_n;
    assign irq       = s_reg.irq;

    // helper: counts between cycle starts and reset-phase length
    logic [15:0] gap_cnt;
    logic [15:0] irst_len;
    localparam int START_WAIT = 64;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt  <= 16'h0000;
            irst_len <= 16'h0000;
        end else if (tick) begin
            gap_cnt  <= start_now ? 16'h0000 : gap_cnt + 16'h0001;
            irst_len <= (s_reg.phase == PH_RESET) ? irst_len + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_order;
        $changed(s_reg.phase) |->
            (s_reg.phase == PH_INTEG && $past(s_reg.phase) == PH_NULL) ||
            (s_reg.phase == PH_DEINT && $past(s_reg.phase) == PH_INTEG) ||
            (s_reg.phase == PH_RESET && $past(s_reg.phase) == PH_DEINT) ||
            (s_reg.phase == PH_NULL && $past(s_reg.phase) == PH_RESET);
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");
    property p_null_sw;
        s_reg.phase == PH_NULL |-> sw == SW_NULL;
    endproperty
    a_null_sw: assert property (p_null_sw) else $error("null switches wrong");
    property p_integ_sw;
        s_reg.phase == PH_INTEG |-> sw.in_to_pins && !sw.offset_loop && !sw.in_short;
    endproperty
    a_integ_sw: assert property (p_integ_sw) else $error("integrate switches wrong");
    property p_pol;
        $changed(s_reg.phase) && s_reg.phase == PH_DEINT |->
            polarity == $past(integ_pos) && s_reg.pol_int == polarity && !overrange;
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not caught");
    property p_ramp_sw;
        s_reg.phase == PH_DEINT |-> sw.neg_to_common && sw.ref_to_pos &&
            sw.ref_pol_pos == !polarity;
    endproperty
    a_ramp_sw: assert property (p_ramp_sw) else $error("ramp switches wrong");
    property p_result;
        $fell(busy) |-> s_reg.result == $past(s_reg.ph_cnt) && s_reg.phase == PH_RESET;
    endproperty
    a_result: assert property (p_result) else $error("result not loaded");
    property p_irst_sw;
        s_reg.phase == PH_RESET |-> sw.neg_to_common && sw.reset_loop && !sw.ref_to_pos;
    endproperty
    a_irst_sw: assert property (p_irst_sw) else $error("reset switches wrong");
    property p_irst_len;
        $changed(s_reg.phase) && s_reg.phase == PH_NULL |->
            irst_len == (s_reg.ovr_irst ? IRST_O_LAST : IRST_N_LAST) + 16'h0001;
    endproperty
    a_irst_len: assert property (p_irst_len) else $error("reset length wrong");
    property p_free_run;
        tick && start_now && !s_reg.held |-> gap_cnt == LAST_POS;
    endproperty
    a_free_run: assert property (p_free_run) else $error("cycle spacing wrong");
    property p_hold;
        s_reg.held && !s_reg.kick |=> s_reg.phase == PH_NULL && !busy;
    endproperty
    a_hold: assert property (p_hold) else $error("left hold unprompted");
    property p_start;
        s_reg.held && s_reg.kick |-> ##[1:START_WAIT] busy;
    endproperty
    a_start: assert property (p_start) else $error("start pulse not honoured");
    property p_ignore;
        !s_reg.held |=> !s_reg.kick;
    endproperty
    a_ignore: assert property (p_ignore) else $error("early start accepted");
    property p_strobe;
        $fell(strobe_n) |-> $past(s_reg.stb_cnt) == STB_LAST ##1 strobe_n || !tick;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe timing wrong");
    property p_busy;
        $rose(busy) |-> s_reg.phase == PH_INTEG && s_reg.ph_cnt == 16'h0000;
    endproperty
    a_busy: assert property (p_busy) else $error("busy rose off phase");
    property p_int_len;
        $changed(s_reg.phase) && s_reg.phase == PH_DEINT |-> $past(s_reg.ph_cnt) == INT_LAST;
    endproperty
    a_int_len: assert property (p_int_len) else $error("integrate length wrong");
endmodule

// >>> testbench/dss_front.sv
module dss_front import dss_pkg::*; (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // switch state from the sequencer
    input  wire dss_sw_t     sw,
    // modelled input: sign and size in counts
    input  wire logic        vin_pos,
    input  wire logic [15:0] vin_cnt,
    // comparator
    output logic             integ_pos
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] ramp_cnt;
    logic        wobble;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_cnt <= 16'h0000;
            wobble   <= 1'b0;
        end else begin
            wobble   <= ~wobble;
            ramp_cnt <= sw.ref_to_pos ? ramp_cnt + 16'h0001 : 16'h0000;
        end
    end

    // outside integrate and ramp the comparator output means nothing, so it toggles
    always_comb begin
        if (sw.in_to_pins) begin
            integ_pos = vin_pos;
        end else if (sw.ref_to_pos) begin
            integ_pos = (ramp_cnt >= vin_cnt) ? ~vin_pos : vin_pos;
        end else begin
            integ_pos = wobble;
        end
    end
endmodule

// >>> testbench/dss_seq_tb.sv
module dss_seq_tb import dss_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // shortened counts keep the run brief
    localparam int CYC = 400;
    localparam int ITG = 100;
    localparam int RNG = 200;
    localparam int ZOV = 62;

    typedef struct {
        string       nm;
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] mask;
    } dss_note_t;

    logic        clk;
    logic        rst_n;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        run_hold;
    logic        integ_pos;
    logic        vin_pos;
    logic [15:0] vin_cnt;
    dss_sw_t     sw;
    logic        busy;
    logic        overrange;
    logic        polarity;
    logic        strobe_n;
    logic        irq;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc_n = 0;
    int          n;
    int          t0;
    int          r;
    int          e;
    dss_note_t   notes[$];

    dss_seq #(.CYCLE(CYC), .INTEG(ITG), .RANGE(RNG), .IRST_OVR(ZOV), .DIV(1)) dss_seq_inst (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .run_hold(run_hold), .integ_pos(integ_pos), .sw(sw), .busy(busy),
        .overrange(overrange), .polarity(polarity), .strobe_n(strobe_n), .irq(irq));

    dss_front dss_front_inst (
        .clk(clk), .rst_n(rst_n), .sw(sw), .vin_pos(vin_pos), .vin_cnt(vin_cnt),
        .integ_pos(integ_pos));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic finish_test();
        if (notes.size() != 0) fail_count++;
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // classic single cycle; released only at the edge that sees ack
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_wdat <= dat;
        wb_sel  <= 4'hf;
        // only the bench timeout ends a wait for ack
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] adr, input logic [31:0] lo,
                      input logic [31:0] hi, input logic [31:0] mask);
        notes.push_back('{nm, lo, hi, mask});
        wb(1'b0, adr, 32'h0);
    endtask

    // cycles until a watched output reaches a level, or lim if it never does
    task automatic wt(input int s, input logic lvl, input int lim, output int k);
        logic v;
        k = 0;
        forever begin
            case (s)
                0: v = busy;
                1: v = sw.ref_to_pos;
                2: v = sw.reset_loop;
                3: v = strobe_n;
                default: v = irq;
            endcase
            if (v === lvl || k >= lim) break;
            @(posedge clk);
            k++;
        end
    endtask

    // read results are judged against the oldest note, a range where timing is loose
    always @(posedge clk) begin
        dss_note_t   nt;
        logic [31:0] v;
        if (wb_ack === 1'b1 && wb_we === 1'b0) begin
            if (notes.size() > 0) begin
                nt = notes.pop_front();
            end else begin
                nt.nm   = "none";
                nt.lo   = 32'h1;
                nt.hi   = 32'h0;
                nt.mask = 32'h0;
            end
            v = wb_rdat & nt.mask;
            n_tests++;
            if ($isunknown(v) || v < nt.lo || v > nt.hi) begin
                fail_count++;
                $display("unexpected %s: expected %h, seen %h", nt.nm, nt.lo, v);
            end
        end
    end

    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 8000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_wdat = 32'h0;
        run_hold = 1'b1;
        vin_pos = 1'b1;
        vin_cnt = 16'h0014;
        void'($urandom(46862));
        repeat (2) @(posedge clk);
        chk("sw_null", 32'he0, sw);
        rst_n <= 1'b1;
        rd("ctrl", ADR_CTRL, 32'h1, 32'h1, 32'h1);
        rd("irq_mask", ADR_IRQ_MASK, 32'h0, 32'h0, 32'h7);
        rd("status", ADR_STATUS, 32'h0, 32'h0, 32'h3f);
        wb(1'b1, 8'h14, 32'hffffffff);
        rd("unmapped", 8'h14, 32'h0, 32'h0, 32'hffffffff);
        wb(1'b1, ADR_IRQ_MASK, 32'h7);
        for (int m = 0; m < 3; m++) begin
            r = (m == 1) ? 250 : 20 + int'($urandom % 100);
            e = (r > RNG) ? RNG : r;
            vin_cnt <= r[15:0];
            vin_pos <= 1'($urandom % 2);
            wt(0, 1'b1, 2 * CYC, n);
            if (m > 0) chk("period", CYC, cyc_n - t0);
            t0 = cyc_n;
            chk("sw_integ", 32'h10, sw & 8'hb4);
            wt(1, 1'b1, 2 * CYC, n);
            chk("integ_len", ITG, n);
            chk("polarity", vin_pos, polarity);
            chk("sw_ramp", 32'h0c | {30'h0, ~vin_pos, 1'b0}, sw & 8'h9e);
            if (m == 2) begin
                chk("ovr_clear", 0, overrange);
                run_hold <= 1'b0;
                @(posedge clk);
                run_hold <= 1'b1;
                repeat (START_CYC + 2) @(posedge clk);
                run_hold <= 1'b0;
            end
            wt(0, 1'b0, 2 * CYC, n);
            wt(2, 1'b1, 10, n);
            chk("sw_reset", 32'h09, sw & 8'h1d);
            wt(2, 1'b0, CYC, n);
            chk("reset_len", (m == 1) ? ZOV : IRST_NORM_COUNTS, n);
            chk("overrange", m == 1, overrange);
            rd("result", ADR_RESULT, e - 1, e + 1, 32'hffff);
            chk("irq_done", 1, irq);
        end
        // a start pulse seen mid-measurement must not restart it
        wt(0, 1'b1, 2 * CYC, n);
        chk("held", 2 * CYC, n);
        rd("held_bit", ADR_STATUS, 32'h20, 32'h20, 32'h20);
        rd("irq_stat", ADR_IRQ_STAT, 32'h7, 32'h7, 32'h7);
        wb(1'b1, ADR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_masked", 0, irq);
        wb(1'b1, ADR_IRQ_STAT, 32'h7);
        rd("irq_clr", ADR_IRQ_STAT, 32'h0, 32'h0, 32'h7);
        wb(1'b1, ADR_IRQ_MASK, 32'h4);
        wb(1'b1, ADR_CTRL, 32'h0);
        rd("ctrl_off", ADR_CTRL, 32'h0, 32'h0, 32'h1);
        wb(1'b1, ADR_CTRL, 32'h1);
        // held for far longer than 101 counts, so a start pulse is legal now
        run_hold <= 1'b1;
        t0 = cyc_n;
        repeat (START_CYC) @(posedge clk);
        run_hold <= 1'b0;
        wt(0, 1'b1, 40, n);
        chk("start_lat", 1, cyc_n - t0 <= START_CYC + 12);
        wt(4, 1'b1, 2 * CYC, n);
        chk("irq_end", 1, irq);
        wt(3, 1'b0, STROBE_DLY + 5, n);
        chk("strobe_dly", 1, n >= STROBE_DLY - 2 && n <= STROBE_DLY + 1);
        @(posedge clk);
        chk("strobe_len", 1, strobe_n);
        finish_test();
    end
endmodule
